//--- vector_map.vh
// constants for reset and interrupt vector placement
`ifndef VECTOR_MAP_VH
`define VECTOR_MAP_VH
`define PC_W             12
`define SRC_N            18
`define SRC_IDX_W        5
`define RESET_ADDR_APP   12'h000
`define VEC_BASE_APP     12'h001
`define VEC_OFS_FIRST    12'h001
`define BOOT_START_DEF   12'hC00
`define FUSE_PROGRAMMED  1'b0
`define UNLOCK_CYCLES    3'h4
`define UNLOCK_CNT_W     3
`define UNLOCK_STEP      3'h1
`define CTRL_PAD         6'h00
`define SRC_PAD          7'h00
`define CTRL_SEL_BIT     1
`define CTRL_UNLOCK_BIT  0
`define CTRL_W           8
`endif

//--- vector_priority.v
// lowest-index pending request picker
`timescale 1ns/1ps
module vector_priority (
    input  wire [17:0] pending,
    output reg         any_pending,
    output reg  [4:0]  winner
);
`include "vector_map.vh"
    integer i;
    always @* begin
        any_pending = 1'b0;
        winner      = 5'h00;
        // scan downward so the lowest index is written last and wins
        for (i = `SRC_N - 1; i >= 0; i = i - 1) begin
            if (pending[i]) begin
                any_pending = 1'b1;
                winner      = i[4:0];
            end
        end
    end
endmodule

//--- vector_placement.v
// reset and interrupt vector address generation and table relocation
`timescale 1ns/1ps
module vector_placement (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        boot_reset_select_fuse,
    input  wire [11:0] boot_start_addr,
    input  wire        ctrl_wr,
    input  wire [7:0]  ctrl_wdata,
    input  wire        instr_done,
    input  wire        global_irq_enable,
    input  wire [17:0] irq_request,
    input  wire [17:0] irq_enable,
    input  wire        irq_ack,
    output wire [11:0] reset_addr,
    output wire        irq_take,
    output wire [4:0]  irq_source,
    output wire [11:0] irq_vector_addr,
    output reg         irq_blocked,
    output wire [7:0]  general_irq_control
);
`include "vector_map.vh"

////////////////////////////////////////////////////////////////////////////////
// helpers

    function [11:0] vector_address;
        input        sel;
        input [11:0] boot_base;
        input [4:0]  src;
        begin
            // src 0 is vector number 2, so slot offset is src plus one
            vector_address = (sel ? boot_base : `RESET_ADDR_APP)
                           + {`SRC_PAD, src} + `VEC_OFS_FIRST;
        end
    endfunction

////////////////////////////////////////////////////////////////////////////////
// control register state

    // window states: idle, unlock open, select written and waiting for one instruction
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_OPEN = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    reg [2:0]                state_reg;
    reg [2:0]                state_next;
    reg                      vector_table_select_reg;
    reg                      vector_table_select_next;
    reg [`UNLOCK_CNT_W-1:0]  unlock_cnt_reg;
    reg [`UNLOCK_CNT_W-1:0]  unlock_cnt_next;
    reg                      irq_blocked_next;

    wire                     wr_unlock;
    wire                     wr_select;
    wire                     unlock_open;
    wire                     window_end;

    assign wr_unlock   = ctrl_wr & ctrl_wdata[`CTRL_UNLOCK_BIT];
    assign wr_select   = ctrl_wr & ~ctrl_wdata[`CTRL_UNLOCK_BIT];
    // unlock bit reads back as one only while the window is open
    assign unlock_open = (state_reg == ST_OPEN);
    assign window_end  = (unlock_cnt_reg == `UNLOCK_CYCLES - `UNLOCK_STEP);

    always @* begin
        state_next               = state_reg;
        vector_table_select_next = vector_table_select_reg;
        unlock_cnt_next          = unlock_cnt_reg;
        irq_blocked_next         = irq_blocked;
        case (state_reg)
            ST_IDLE: begin
                if (wr_unlock) begin
                    state_next       = ST_OPEN;
                    unlock_cnt_next  = {`UNLOCK_CNT_W{1'b0}};
                    irq_blocked_next = 1'b1;
                end
            end
            ST_OPEN: begin
                if (wr_unlock) begin
                    // a fresh unlock restarts the window
                    unlock_cnt_next  = {`UNLOCK_CNT_W{1'b0}};
                    irq_blocked_next = 1'b1;
                end else if (wr_select) begin
                    // select only changes while unlocked, with unlock written zero
                    vector_table_select_next = ctrl_wdata[`CTRL_SEL_BIT];
                    state_next               = ST_HOLD;
                end else if (window_end) begin
                    state_next       = ST_IDLE;
                    irq_blocked_next = 1'b0;
                end else begin
                    unlock_cnt_next = unlock_cnt_reg + `UNLOCK_STEP;
                end
            end
            ST_HOLD: begin
                if (wr_unlock) begin
                    state_next       = ST_OPEN;
                    unlock_cnt_next  = {`UNLOCK_CNT_W{1'b0}};
                    irq_blocked_next = 1'b1;
                end else if (instr_done) begin
                    // instruction after the select write finished
                    state_next       = ST_IDLE;
                    irq_blocked_next = 1'b0;
                end
            end
            default: begin
                // an illegal code falls back to idle with nothing blocked
                state_next       = ST_IDLE;
                irq_blocked_next = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_table_select_reg <= 1'b0;
        end else begin
            vector_table_select_reg <= vector_table_select_next;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_cnt_reg <= {`UNLOCK_CNT_W{1'b0}};
        end else begin
            unlock_cnt_reg <= unlock_cnt_next;
        end
    end

    // the block never touches the core's global enable, only this private gate
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_blocked <= 1'b0;
        end else begin
            irq_blocked <= irq_blocked_next;
        end
    end

    assign general_irq_control = {`CTRL_PAD, vector_table_select_reg, unlock_open};

////////////////////////////////////////////////////////////////////////////////
// reset address

    // fuse decoded alone; table select has no say in where reset lands
    assign reset_addr = (boot_reset_select_fuse == `FUSE_PROGRAMMED)
                      ? boot_start_addr : `RESET_ADDR_APP;

////////////////////////////////////////////////////////////////////////////////
// vector selection

    wire [17:0] pending = irq_request & irq_enable;
    wire        any_pending;
    wire [4:0]  winner;

    vector_priority u_prio (
        .pending     (pending),
        .any_pending (any_pending),
        .winner      (winner)
    );

    // slots are fetched only on a taken enabled request
    assign irq_take        = any_pending & global_irq_enable & ~irq_blocked;
    assign irq_source      = winner;
    // sources in order give offsets 0x001..0x012
    assign irq_vector_addr = vector_address(vector_table_select_reg, boot_start_addr,
                                            winner);
endmodule

//--- core_model.sv
// partner model: core fetch side retiring instructions
`timescale 1ns/1ps
module core_model (
    input wire clk,
    input wire rst_n,
    input wire slow,
    output reg instr_done
);
reg [1:0] cnt_reg;
// slow mode retires one instruction every fourth cycle, stretching the block window
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_reg <= 2'h0;
        instr_done <= 1'b0;
    end else begin
        cnt_reg <= cnt_reg + 2'h1;
        instr_done <= !slow || cnt_reg == 2'h3;
    end
end
endmodule

//--- vector_placement_assertions.sv
// assertions for vector placement
`timescale 1ns/1ps
module vector_placement_chk (
    input wire clk,
    input wire rst_n,
    input wire boot_reset_select_fuse,
    input wire [11:0] boot_start_addr,
    input wire ctrl_wr,
    input wire [7:0] ctrl_wdata,
    input wire [17:0] irq_request,
    input wire [17:0] irq_enable,
    input wire irq_take,
    input wire [4:0] irq_source,
    input wire [11:0] reset_addr,
    input wire [11:0] irq_vector_addr,
    input wire irq_blocked,
    input wire [7:0] general_irq_control
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
wire [17:0] live = irq_request & irq_enable;
wire unl = general_irq_control[0];
wire sel = general_irq_control[1];
////////////////////////////////////////////////////////////////////////////////
property p_app; boot_reset_select_fuse |-> reset_addr == 12'h000; endproperty
a_app: assert property (p_app) else $error("app reset addr");
property p_boot; !boot_reset_select_fuse |-> reset_addr == boot_start_addr; endproperty
a_boot: assert property (p_boot) else $error("boot reset addr");
property p_vec;
    irq_take |-> irq_vector_addr == (sel ? boot_start_addr : 12'h000) + irq_source + 12'h001;
endproperty
a_vec: assert property (p_vec) else $error("vector addr");
property p_pri;
    irq_take |-> live[irq_source] && (live & ((18'h1 << irq_source) - 18'h1)) == 18'h0;
endproperty
a_pri: assert property (p_pri) else $error("priority");
property p_unl; ctrl_wr && ctrl_wdata[0] |=> unl && irq_blocked; endproperty
a_unl: assert property (p_unl) else $error("unlock set");
property p_to; ctrl_wr && ctrl_wdata[0] ##1 !ctrl_wr [*4] |=> !unl && !irq_blocked; endproperty
a_to: assert property (p_to) else $error("unlock timeout");
property p_sel; ctrl_wr && !ctrl_wdata[0] && unl |=> sel == $past(ctrl_wdata[1]) && !unl; endproperty
a_sel: assert property (p_sel) else $error("select write");
property p_ref; !(ctrl_wr && unl) |=> $stable(sel); endproperty
a_ref: assert property (p_ref) else $error("select changed");
property p_blk; irq_blocked |-> !irq_take; endproperty
a_blk: assert property (p_blk) else $error("taken while blocked");
c_move: cover property (ctrl_wr && ctrl_wdata[0] ##1 ctrl_wr && ctrl_wdata == 8'h02);
c_take: cover property (irq_take && sel);
c_to: cover property ($fell(unl) && !sel);
endmodule
bind vector_placement vector_placement_chk chk (.*);

//--- vector_placement_test.sv
// testbench for vector placement
`timescale 1ns/1ps
module vector_placement_test;
reg clk = 0, rst_n = 0, fuse = 1, wr = 0, slow = 0;
reg [7:0] wd = 8'h00;
reg [17:0] rq = 18'h0;
wire done, take, blk;
wire [11:0] ra, va;
wire [4:0] src;
wire [7:0] gic;
integer errors = 0, n_tests = 0, i;
always #5 clk = ~clk;
core_model cm (.clk(clk), .rst_n(rst_n), .slow(slow), .instr_done(done));
vector_placement dut (.clk(clk), .rst_n(rst_n), .boot_reset_select_fuse(fuse),
    .boot_start_addr(12'hC00), .ctrl_wr(wr), .ctrl_wdata(wd), .instr_done(done),
    .global_irq_enable(1'b1), .irq_request(rq), .irq_enable(18'h3FFFF), .irq_ack(1'b0),
    .reset_addr(ra), .irq_take(take), .irq_source(src), .irq_vector_addr(va),
    .irq_blocked(blk), .general_irq_control(gic));
////////////////////////////////////////////////////////////////////////////////
task chk(input [11:0] g, input [11:0] e); begin
    n_tests = n_tests + 1;
    if (g !== e) begin
        errors = errors + 1;
        $display("ERROR %0t got %h exp %h", $time, g, e);
    end
end endtask
task summarize; begin
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
end endtask
// keep holds the strobe up so a following write does not re-raise it in the same step
task w(input [7:0] d, input keep); begin
    wr = 1; wd = d; @(negedge clk);
    if (!keep) wr = 0;
end endtask
////////////////////////////////////////////////////////////////////////////////
task t_vec; begin
    chk(ra, 12'h000);
    fuse = 0; #1 chk(ra, 12'hC00);
    fuse = 1;
    for (i = 0; i < 18; i = i + 1) begin
        rq = 18'h1 << i; @(negedge clk);
        chk(va, 12'h001 + i);
        chk(take, 12'h1);
    end
    rq = 18'h3FFF6; @(negedge clk); chk(src, 12'h001);
end endtask
task t_move; begin
    rq = 18'h20; w(8'h01, 1); chk(gic, 12'h001); chk(take, 12'h0);
    w(8'h02, 0); chk(gic, 12'h002); chk(va, 12'hC06);
    chk(blk, 12'h1);
    for (i = 0; i < 20 && blk; i = i + 1) @(negedge clk);
    chk(blk, 12'h0);
    if (blk) summarize;
    w(8'h00, 0); chk(gic, 12'h002);
end endtask
task t_timeout; begin
    slow = 1; w(8'h01, 0); repeat (3) @(negedge clk);
    chk(gic, 12'h003);
    @(negedge clk); chk(gic, 12'h002); chk(blk, 12'h0);
    chk(take, 12'h1);
end endtask
initial begin
    repeat (10) @(negedge clk);
    rst_n = 1; @(negedge clk);
    t_vec; t_move; t_timeout; summarize;
end
endmodule
